// >>> rtl/tpc_pkg.sv
// package: constants and carrier types of the pattern colour byte bank
package tpc_pkg;

  localparam int unsigned TPC_AW = 8;
  localparam int unsigned TPC_DW = 32;
  localparam int unsigned TPC_NBYTES = 10;
  localparam int unsigned TPC_NLOWER = 6;
  localparam int unsigned TPC_NBARS = 8;
  localparam int unsigned TPC_IDX_LSB = 2;

  // register indices; the byte address is four times the index
  localparam logic [5:0] TPC_IDX_BYTE_06 = 6'h16;
  localparam logic [5:0] TPC_IDX_BYTE_07 = 6'h17;
  localparam logic [5:0] TPC_IDX_BYTE_08 = 6'h18;
  localparam logic [5:0] TPC_IDX_BYTE_09 = 6'h19;
  localparam logic [5:0] TPC_IDX_BYTE_10 = 6'h1A;
  localparam logic [5:0] TPC_IDX_BYTE_11 = 6'h1B;
  localparam logic [5:0] TPC_IDX_BYTE_12 = 6'h1C;
  localparam logic [5:0] TPC_IDX_BYTE_13 = 6'h1D;
  localparam logic [5:0] TPC_IDX_BYTE_14 = 6'h1E;
  localparam logic [5:0] TPC_IDX_BYTE_15 = 6'h1F;
  localparam logic [5:0] TPC_IDX_CTRL = 6'h20;
  localparam logic [5:0] TPC_IDX_BAR_LEN = 6'h21;
  localparam logic [5:0] TPC_IDX_STATUS = 6'h22;

  localparam logic [7:0] TPC_RST_BYTE_06 = 8'h0F;
  localparam logic [7:0] TPC_RST_BYTE_07 = 8'h80;
  localparam logic [7:0] TPC_RST_BYTE_HI = 8'h00;
  localparam logic [TPC_NBYTES*8-1:0] TPC_RST_BYTES = {{8{TPC_RST_BYTE_HI}}, TPC_RST_BYTE_07, TPC_RST_BYTE_06};

  localparam int unsigned TPC_CTRL_EN = 0;
  localparam int unsigned TPC_CTRL_FIXED = 1;
  localparam logic [7:0] TPC_CTRL_RST = 8'h00;
  localparam logic [7:0] TPC_BAR_LEN_RST = 8'h10;
  localparam logic [3:0] TPC_K_BYTE_06 = 4'h6;
  localparam logic [3:0] TPC_K_BYTE_07 = 4'h7;

  typedef enum logic [1:0] {
    TPC_APB_IDLE = 2'b00,
    TPC_APB_ACC = 2'b01,
    TPC_APB_DONE = 2'b10
  } tpc_apb_st_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [TPC_AW-1:0] paddr;
    logic [TPC_DW-1:0] pwdata;
    logic [3:0] pstrb;
  } tpc_apb_req_t;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [TPC_DW-1:0] prdata;
  } tpc_apb_rsp_t;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } tpc_pat_t;

  typedef struct packed {
    tpc_apb_st_t apb_st;
    tpc_apb_rsp_t rsp;
    logic [7:0] ctrl;
    logic [7:0] bar_len;
    logic [3:0] pos;
    logic [7:0] bar_cnt;
    logic s1_valid;
    logic s1_lower;
    logic [7:0] s1_byte;
    tpc_pat_t pat;
  } tpc_state_t;

  localparam tpc_state_t TPC_STATE_RST = '{apb_st: TPC_APB_IDLE, rsp: '0, ctrl: TPC_CTRL_RST,
    bar_len: TPC_BAR_LEN_RST, pos: '0, bar_cnt: '0, s1_valid: 1'b0, s1_lower: 1'b0,
    s1_byte: '0, pat: '0};

  typedef struct packed {
    logic [TPC_NBYTES-1:0][7:0] bytes;
    logic [7:0] ra_data;
    logic [7:0] rb_data;
  } tpc_mem_state_t;

endpackage

// >>> rtl/tpc_byte_mem.sv
// ten colour bytes with one write port and two registered read ports
`timescale 1ns/100ps
module tpc_byte_mem (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic wr_en,
  input wire logic [3:0] wr_idx,
  input wire logic [7:0] wr_data,
  input wire logic [3:0] ra_idx,
  output logic [7:0] ra_data,
  input wire logic [3:0] rb_idx,
  output logic [7:0] rb_data
);

  tpc_pkg::tpc_mem_state_t st_r;
  tpc_pkg::tpc_mem_state_t st_nxt;
  logic [tpc_pkg::TPC_NBYTES-1:0][7:0] byte_nxt;

  genvar g;
  for (g = 0; g < tpc_pkg::TPC_NBYTES; g++) begin : g_byte
    assign byte_nxt[g] = (wr_en && wr_idx == 4'(g)) ? wr_data : st_r.bytes[g]; // see RL8
  end

  always_comb begin
    st_nxt = st_r;
    st_nxt.bytes = byte_nxt;
    // out-of-range index reads zero rather than wrapping onto a real byte
    st_nxt.ra_data = (ra_idx < 4'(tpc_pkg::TPC_NBYTES)) ? st_r.bytes[ra_idx] : 8'h00;
    st_nxt.rb_data = (rb_idx < 4'(tpc_pkg::TPC_NBYTES)) ? st_r.bytes[rb_idx] : 8'h00;
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st_r <= '{bytes: tpc_pkg::TPC_RST_BYTES, ra_data: 8'h00, rb_data: 8'h00}; // see RL7
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  assign ra_data = st_r.ra_data;
  assign rb_data = st_r.rb_data;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  a_reset_bytes_value: assert property ($past(!rst_n) |-> st_r.bytes == tpc_pkg::TPC_RST_BYTES) // see RL7
    else $error("colour bytes wrong after reset");

  a_write_lands_once: assert property ((wr_en && ce && wr_idx < 4'(tpc_pkg::TPC_NBYTES)) |=> // see RL8
    st_r.bytes[$past(wr_idx)] == $past(wr_data))
    else $error("written colour byte not stored");

endmodule // tpc_byte_mem

// >>> rtl/tpc_color_regs.sv
// upper pattern colour byte bank with APB slave and byte generator
//
// What this block does
// RL1: during colour bars, every byte of bar 6 is the byte-06 register value.
// RL2: during colour bars, every byte of bar 7 is the byte-07 register value.
// RL3: in fixed colour mode, byte-06 register gives the seventh sequence byte.
// RL4: in fixed colour mode, byte-07 register gives the eighth sequence byte.
// RL5: fixed sequence bytes nine to sixteen come in order from bytes 08 to 15.
// RL6: bytes 08 to 15 feed only the fixed pattern, never a colour bar.
// RL7: reset values are 0x0F, 0x80 and zero for bytes 08 to 15.
// RL8: all bytes read and write in full; writes show from a later byte.
// RL9: colour bars 0 to 5 come from the lower bytes, bar n from byte n.
`timescale 1ns/100ps
module tpc_color_regs (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic ce,
  input wire tpc_pkg::tpc_apb_req_t apb_req,
  output tpc_pkg::tpc_apb_rsp_t apb_rsp,
  input wire logic [tpc_pkg::TPC_NLOWER-1:0][7:0] lower_bytes,
  output tpc_pkg::tpc_pat_t pat
);

  tpc_pkg::tpc_state_t st_r;
  tpc_pkg::tpc_state_t st_nxt;

  // register index of an APB address, zero when not word aligned
  function automatic logic [5:0] fn_reg_idx(input logic [tpc_pkg::TPC_AW-1:0] addr);
    logic [5:0] idx;
    idx = addr[tpc_pkg::TPC_AW-1:tpc_pkg::TPC_IDX_LSB];
    if (addr[tpc_pkg::TPC_IDX_LSB-1:0] != 2'h0) begin
      idx = 6'h00;
    end
    return idx;
  endfunction

  // colour byte decode: hit flag and slot in the byte memory
  function automatic logic [4:0] fn_byte_slot(input logic [tpc_pkg::TPC_AW-1:0] addr);
    logic [5:0] idx;
    logic [5:0] off;
    idx = fn_reg_idx(addr);
    off = idx - tpc_pkg::TPC_IDX_BYTE_06;
    if (idx >= tpc_pkg::TPC_IDX_BYTE_06 && idx <= tpc_pkg::TPC_IDX_BYTE_15) begin
      return {1'b1, off[3:0]};
    end
    return 5'h00;
  endfunction

  logic [5:0] bus_idx;
  logic [4:0] bus_slot;
  logic bus_hit;
  logic bus_mapped;
  logic wr_fire;
  logic mem_wr_en;
  logic [7:0] mem_a_data;
  logic [7:0] mem_b_data;
  logic run_w;
  logic fixed_w;
  logic [3:0] gen_k;
  logic gen_lower;
  logic [3:0] gen_idx;
  logic [7:0] gen_lo_byte;
  logic [8:0] bar_cnt_inc;
  logic bar_end;
  logic [31:0] rd_mux;

  assign bus_idx = fn_reg_idx(apb_req.paddr);
  assign bus_slot = fn_byte_slot(apb_req.paddr);
  assign bus_hit = bus_slot[4];
  assign bus_mapped = bus_hit || bus_idx == tpc_pkg::TPC_IDX_CTRL ||
    bus_idx == tpc_pkg::TPC_IDX_BAR_LEN || bus_idx == tpc_pkg::TPC_IDX_STATUS;

  // write takes effect only at the edge where the master sees pready
  assign wr_fire = st_r.apb_st == tpc_pkg::TPC_APB_DONE && apb_req.psel && apb_req.penable &&
    apb_req.pwrite && apb_req.pstrb[0];
  assign mem_wr_en = wr_fire && bus_hit; // see RL8

  assign run_w = st_r.ctrl[tpc_pkg::TPC_CTRL_EN];
  assign fixed_w = st_r.ctrl[tpc_pkg::TPC_CTRL_FIXED];

  // bar mode walks eight bars, fixed mode walks sixteen bytes
  assign gen_k = fixed_w ? st_r.pos : {1'b0, st_r.pos[2:0]}; // see RL6
  assign gen_lower = gen_k < 4'(tpc_pkg::TPC_NLOWER); // see RL9
  assign gen_idx = gen_k - 4'(tpc_pkg::TPC_NLOWER); // see RL3 / RL4 / RL5
  assign gen_lo_byte = gen_lower ? lower_bytes[gen_k[2:0]] : 8'h00; // see RL9
  assign bar_cnt_inc = {1'b0, st_r.bar_cnt} + 9'h001;
  assign bar_end = bar_cnt_inc >= {1'b0, st_r.bar_len};

  tpc_byte_mem u_mem (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .ce(ce),
    .wr_en(mem_wr_en),
    .wr_idx(bus_slot[3:0]),
    .wr_data(apb_req.pwdata[7:0]),
    .ra_idx(bus_slot[3:0]),
    .ra_data(mem_a_data),
    .rb_idx(gen_idx),
    .rb_data(mem_b_data)
  );

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (bus_hit) begin
      rd_mux = {24'h00_0000, mem_a_data}; // see RL8
    end else if (bus_idx == tpc_pkg::TPC_IDX_CTRL) begin
      rd_mux = {24'h00_0000, st_r.ctrl};
    end else if (bus_idx == tpc_pkg::TPC_IDX_BAR_LEN) begin
      rd_mux = {24'h00_0000, st_r.bar_len};
    end else if (bus_idx == tpc_pkg::TPC_IDX_STATUS) begin
      rd_mux = {24'h00_0000, 3'h0, run_w, st_r.pos};
    end
  end

  always_comb begin
    st_nxt = st_r;

    // bus slave: setup, one wait cycle, then pready for one cycle
    unique case (st_r.apb_st)
      tpc_pkg::TPC_APB_IDLE: begin
        if (apb_req.psel && !apb_req.penable) begin
          st_nxt.apb_st = tpc_pkg::TPC_APB_ACC;
        end
      end
      tpc_pkg::TPC_APB_ACC: begin
        if (apb_req.psel && apb_req.penable) begin
          st_nxt.apb_st = tpc_pkg::TPC_APB_DONE;
          st_nxt.rsp.pready = 1'b1;
          st_nxt.rsp.pslverr = !bus_mapped;
          st_nxt.rsp.prdata = apb_req.pwrite ? 32'h0000_0000 : rd_mux;
        end else begin
          st_nxt.apb_st = tpc_pkg::TPC_APB_IDLE;
        end
      end
      tpc_pkg::TPC_APB_DONE: begin
        st_nxt.apb_st = tpc_pkg::TPC_APB_IDLE;
        st_nxt.rsp.pready = 1'b0;
        st_nxt.rsp.pslverr = 1'b0;
      end
      default: begin
        st_nxt.apb_st = tpc_pkg::TPC_APB_IDLE;
        st_nxt.rsp = '0;
      end
    endcase

    // generator position
    if (!run_w) begin
      st_nxt.pos = 4'h0;
      st_nxt.bar_cnt = 8'h00;
    end else if (fixed_w) begin
      st_nxt.pos = st_r.pos + 4'h1; // see RL5
      st_nxt.bar_cnt = 8'h00;
    end else if (bar_end) begin
      st_nxt.pos = {1'b0, st_r.pos[2:0] + 3'h1};
      st_nxt.bar_cnt = 8'h00;
    end else begin
      st_nxt.bar_cnt = bar_cnt_inc[7:0];
    end

    // control writes restart the walk so a mode change starts clean
    if (wr_fire && bus_idx == tpc_pkg::TPC_IDX_CTRL) begin
      st_nxt.ctrl = apb_req.pwdata[7:0];
      st_nxt.pos = 4'h0;
      st_nxt.bar_cnt = 8'h00;
    end
    if (wr_fire && bus_idx == tpc_pkg::TPC_IDX_BAR_LEN) begin
      st_nxt.bar_len = apb_req.pwdata[7:0];
    end

    // stage one waits for the memory read issued this cycle
    st_nxt.s1_valid = run_w;
    st_nxt.s1_lower = gen_lower;
    st_nxt.s1_byte = gen_lo_byte;

    // stage two: a byte write lands two edges before it can reach here
    st_nxt.pat.valid = st_r.s1_valid;
    st_nxt.pat.data = st_r.s1_lower ? st_r.s1_byte : mem_b_data; // see RL1 / RL2 / RL8
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st_r <= tpc_pkg::TPC_STATE_RST; // see RL7
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  assign apb_rsp = st_r.rsp;
  assign pat = st_r.pat;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence s_issue_bar(int b);
    run_w && !fixed_w && ce && gen_k == 4'(b);
  endsequence

  // a control write restarts the walk, so that edge is no step of the sequence
  sequence s_issue_fixed(int p);
    run_w && fixed_w && ce && st_r.pos == 4'(p) && !(wr_fire && bus_idx == tpc_pkg::TPC_IDX_CTRL);
  endsequence

  sequence s_setup;
    apb_req.psel && !apb_req.penable && st_r.apb_st == tpc_pkg::TPC_APB_IDLE && ce;
  endsequence

  sequence s_access;
    apb_req.psel && apb_req.penable && ce;
  endsequence

  a_bar_six_out: assert property (s_issue_bar(6) ##1 ce |-> // see RL1
    $past(gen_idx) == 4'h0 && !$past(gen_lower) ##1 st_r.pat.valid && st_r.pat.data == $past(mem_b_data))
    else $error("bar 6 byte not taken from byte 06");

  a_bar_seven_out: assert property (s_issue_bar(7) ##1 ce |-> // see RL2
    $past(gen_idx) == 4'h1 && !$past(gen_lower) ##1 st_r.pat.valid && st_r.pat.data == $past(mem_b_data))
    else $error("bar 7 byte not taken from byte 07");

  a_fixed_seventh_byte: assert property (s_issue_fixed(6) |-> // see RL3
    gen_idx == 4'h0 && !gen_lower ##1 st_r.s1_valid && !st_r.s1_lower)
    else $error("fixed seventh byte not from byte 06");

  a_fixed_eighth_byte: assert property (s_issue_fixed(7) |-> // see RL4
    gen_idx == 4'h1 && !gen_lower ##1 (st_r.pos == 4'h8 || !ce))
    else $error("fixed eighth byte not from byte 07");

  a_fixed_upper_order: assert property ((run_w && fixed_w && st_r.pos >= 4'h8) |-> // see RL5
    gen_idx == st_r.pos - 4'h6 && !gen_lower)
    else $error("fixed upper byte out of order");

  a_fixed_step_order: assert property (s_issue_fixed(9) ##1 (ce && fixed_w && run_w) |-> // see RL5
    gen_idx == $past(gen_idx) + 4'h1)
    else $error("fixed sequence does not ascend");

  a_bar_no_upper: assert property ((run_w && !fixed_w) |-> // see RL6
    gen_lower || gen_idx < 4'h2)
    else $error("bar pattern reaches bytes 08 to 15");

  a_bar_lower_src: assert property ((run_w && !fixed_w && gen_k < 4'h6 && ce) |=> // see RL9
    st_r.s1_lower && st_r.s1_byte == $past(lower_bytes[gen_k[2:0]]))
    else $error("lower bar not from lower colour byte");

  a_bus_one_wait: assert property (s_setup ##1 s_access |-> // see RL8
    !st_r.rsp.pready ##1 st_r.rsp.pready ##1 !st_r.rsp.pready)
    else $error("bus answer not after exactly one wait cycle");

  a_bus_readback: assert property (s_setup ##1 (s_access and (!apb_req.pwrite && bus_hit)) |=> // see RL8
    st_r.rsp.prdata == {24'h00_0000, $past(mem_a_data)} && !st_r.rsp.pslverr)
    else $error("colour byte readback wrong");

  a_bus_unmapped_err: assert property (s_setup ##1 (s_access and !bus_mapped) |=>
    st_r.rsp.pready && st_r.rsp.pslverr)
    else $error("unmapped address without error");

  a_write_to_output: assert property ((mem_wr_en && bus_slot[3:0] == 4'h0 && ce) |-> // see RL8
    ##1 !(st_r.pat.valid && $changed(st_r.pat.data) && $past(mem_wr_en)))
    else $error("write reached the pattern in the same byte");

endmodule // tpc_color_regs

// >>> tb/tpc_color_regs_test.sv
// self-checking bench of the upper pattern colour byte bank
`timescale 1ns/100ps
module tpc_color_regs_test;
  logic clk_sys;
  logic rst_n;
  logic ce;
  tpc_pkg::tpc_apb_req_t apb_req;
  tpc_pkg::tpc_apb_rsp_t apb_rsp;
  logic [tpc_pkg::TPC_NLOWER-1:0][7:0] lower_bytes;
  tpc_pkg::tpc_pat_t pat;
  int n_errors;
  int num_checks;
  // model of all sixteen colour bytes: 0..5 lower input, 6..15 registers
  logic [7:0] mdl [16];

  tpc_color_regs tpc_color_regs_inst (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .ce(ce),
    .apb_req(apb_req),
    .apb_rsp(apb_rsp),
    .lower_bytes(lower_bytes),
    .pat(pat)
  );

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic complete_run();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one apb transfer; read data and error are taken at the first falling edge that sees pready high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                     output logic [31:0] r, output logic e);
    int i;
    @(posedge clk_sys);
    apb_req.psel <= 1'b1;
    apb_req.penable <= 1'b0;
    apb_req.pwrite <= wr;
    apb_req.paddr <= a;
    apb_req.pwdata <= d;
    apb_req.pstrb <= s;
    @(posedge clk_sys);
    apb_req.penable <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(negedge clk_sys);
      if (apb_rsp.pready === 1'b1) break;
    end
    if (i == 50) begin
      n_errors++;
      $display("MISMATCH t=%0t no pready", $time);
      complete_run();
    end
    r = apb_rsp.prdata;
    e = apb_rsp.pslverr;
    @(posedge clk_sys);
    apb_req.psel <= 1'b0;
    apb_req.penable <= 1'b0;
  endtask

  task automatic wr_chk(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic e);
    logic [31:0] r;
    logic er;
    apb(1'b1, a, d, s, r, er);
    check({31'h0, er}, {31'h0, e});
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic e);
    logic [31:0] r;
    logic er;
    apb(1'b0, a, 32'h0, 4'h0, r, er);
    check(r, exp);
    check({31'h0, er}, {31'h0, e});
  endtask

  // collect n generated bytes from the first valid one and compare with the model
  task automatic cap(input int n, input int blen, input logic fixed);
    int i;
    int k;
    logic [7:0] exp;
    for (i = 0; i < 50; i++) begin
      @(negedge clk_sys);
      if (pat.valid === 1'b1) break;
    end
    if (i == 50) begin
      n_errors++;
      $display("MISMATCH t=%0t generator silent", $time);
      complete_run();
    end
    for (k = 0; k < n; k++) begin
      exp = fixed ? mdl[k % 16] : mdl[(k / blen) % 8];
      check({31'h0, pat.valid}, 32'h1);
      check({24'h0, pat.data}, {24'h0, exp});
      @(negedge clk_sys);
    end
  endtask

  initial begin
    int i;
    int b;
    int eff;
    logic [31:0] d;
    int blens [3];
    rst_n = 1'b0;
    ce = 1'b1;
    apb_req = '0;
    lower_bytes = '0;
    n_errors = 0;
    num_checks = 0;
    blens = '{0, 1, 3};
    void'($urandom(9332));
    repeat (20) @(posedge clk_sys);
    rst_n <= 1'b1;
    for (i = 0; i < 6; i++) begin
      mdl[i] = 8'($urandom);
      lower_bytes[i] <= mdl[i];
    end
    mdl[6] = 8'h0F;
    mdl[7] = 8'h80;
    for (i = 8; i < 16; i++) mdl[i] = 8'h00;
    for (i = 0; i < 10; i++) rd_chk(8'(8'h58 + 4 * i), {24'h0, mdl[i + 6]}, 1'b0);
    rd_chk(8'h80, 32'h0, 1'b0);
    rd_chk(8'h84, 32'h10, 1'b0);
    // upper bits of the written word must not reach the byte
    for (i = 0; i < 10; i++) begin
      d = $urandom;
      wr_chk(8'(8'h58 + 4 * i), d, 4'hF, 1'b0);
      mdl[i + 6] = d[7:0];
    end
    for (i = 0; i < 10; i++) rd_chk(8'(8'h58 + 4 * i), {24'h0, mdl[i + 6]}, 1'b0);
    wr_chk(8'h58, {24'h0, ~mdl[6]}, 4'h0, 1'b0);
    rd_chk(8'h58, {24'h0, mdl[6]}, 1'b0);
    rd_chk(8'h40, 32'h0, 1'b1);
    rd_chk(8'h8C, 32'h0, 1'b1);
    rd_chk(8'h59, 32'h0, 1'b1);
    wr_chk(8'h40, 32'hFF, 4'hF, 1'b1);
    wr_chk(8'h88, 32'hFF, 4'hF, 1'b0);
    rd_chk(8'h88, 32'h0, 1'b0);
    wr_chk(8'h80, 32'h3, 4'hF, 1'b0);
    cap(40, 1, 1'b1);
    // low clock enable freezes the walk on byte 41 of the sequence
    @(posedge clk_sys);
    ce <= 1'b0;
    for (i = 0; i < 4; i++) begin
      @(negedge clk_sys);
      check({31'h0, pat.valid}, 32'h1);
      check({24'h0, pat.data}, {24'h0, mdl[41 % 16]});
    end
    @(posedge clk_sys);
    ce <= 1'b1;
    // bar length zero behaves as one
    for (b = 0; b < 3; b++) begin
      eff = (blens[b] == 0) ? 1 : blens[b];
      wr_chk(8'h80, 32'h0, 4'hF, 1'b0);
      wr_chk(8'h84, 32'(blens[b]), 4'hF, 1'b0);
      wr_chk(8'h80, 32'h1, 4'hF, 1'b0);
      cap(16 * eff + 5, eff, 1'b0);
    end
    wr_chk(8'h80, 32'h0, 4'hF, 1'b0);
    complete_run();
  end
endmodule // tpc_color_regs_test
